// [hw/crs_map.vh]
`ifndef CRS_MAP_VH
`define CRS_MAP_VH
// ----------------------------------------------------------------
// Register map on the classic Wishbone slave (byte addresses)
// ----------------------------------------------------------------
`define CRS_ADR_WORK     8'h00
`define CRS_ADR_PAIR     8'h04
`define CRS_ADR_STACK    8'h08
`define CRS_ADR_PC       8'h0c
`define CRS_ADR_FLAG     8'h10
`define CRS_ADR_STATUS   8'h14
// ----------------------------------------------------------------
// Reset values and fixed addresses
// ----------------------------------------------------------------
`define CRS_SP_RESET     16'h00ff
`define CRS_SP_LOW_LOAD  8'hff
`define CRS_RESET_VEC    16'hfffe
`define CRS_IRQ_VEC_TOP  16'hfffc
`define CRS_FLAG_RESET   8'h68
`define CRS_FLAG_FIXED   8'h60
// ----------------------------------------------------------------
// Flag register bit positions
// ----------------------------------------------------------------
`define CRS_F_V          7
`define CRS_F_H          4
`define CRS_F_I          3
`define CRS_F_N          2
`define CRS_F_Z          1
`define CRS_F_C          0
// ----------------------------------------------------------------
// Operations from the sequencer
// ----------------------------------------------------------------
`define CRS_OP_NOP       4'h0
`define CRS_OP_LDA       4'h1
`define CRS_OP_LDHX      4'h2
`define CRS_OP_LDSP      4'h3
`define CRS_OP_JUMP      4'h4
`define CRS_OP_FETCH     4'h5
`define CRS_OP_ALU       4'h6
`define CRS_OP_MASK      4'h7
`define CRS_OP_PUSH_WK   4'h8
`define CRS_OP_PUSH_HI   4'h9
`define CRS_OP_PULL_WK   4'ha
`define CRS_OP_PULL_HI   4'hb
`define CRS_OP_RELOAD    4'hc
`define CRS_OP_UNMASK    4'hd
`define CRS_OP_RETURN    4'hf
// ----------------------------------------------------------------
// Arithmetic and logic functions
// ----------------------------------------------------------------
`define CRS_FN_ADD       4'h0
`define CRS_FN_ADC       4'h1
`define CRS_FN_SUB       4'h2
`define CRS_FN_SBC       4'h3
`define CRS_FN_AND       4'h4
`define CRS_FN_ORA       4'h5
`define CRS_FN_EOR       4'h6
`define CRS_FN_LSL       4'h7
`define CRS_FN_LSR       4'h8
`define CRS_FN_ROL       4'h9
`define CRS_FN_ROR       4'ha
`define CRS_FN_ASR       4'hb
`define CRS_FN_DEC_ADJ   4'hc
// ----------------------------------------------------------------
// Effective address modes
// ----------------------------------------------------------------
`define CRS_EA_DIRECT    2'h0
`define CRS_EA_INDEX     2'h1
`define CRS_EA_STACK     2'h2
`endif

// [hw/crs_flag_unit.v]
`timescale 1ns/1ns
`include "crs_map.vh"
module crs_flag_unit (
  input  wire [3:0] i_fn,      // Function select
  input  wire [7:0] i_a,       // Work register value
  input  wire [7:0] i_b,       // Operand
  input  wire       i_c,       // Carry in
  input  wire       i_h,       // Nibble carry in
  output reg  [7:0] o_res,     // Result
  output reg        o_v,       // Signed wrap
  output reg        o_h,       // Nibble carry
  output reg        o_c,       // Carry or borrow
  output wire       o_n,       // Result MSB
  output wire       o_z        // Null result
);
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] corr;

  assign o_n = o_res[7];
  assign o_z = (o_res == 8'h00);

  always @* begin
    sum   = 9'h000;
    nib   = 5'h00;
    corr  = 8'h00;
    o_res = i_a;
    o_v   = 1'b0;
    o_h   = i_h;
    o_c   = i_c;
    case (i_fn)
      `CRS_FN_ADD, `CRS_FN_ADC: begin
        sum   = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_c & (i_fn == `CRS_FN_ADC)};
        nib   = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_c & (i_fn == `CRS_FN_ADC)};
        o_res = sum[7:0];
        o_h   = nib[4];
        o_c   = sum[8];
        o_v   = (i_a[7] == i_b[7]) && (sum[7] != i_a[7]);
      end
      `CRS_FN_SUB, `CRS_FN_SBC: begin
        sum   = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_c & (i_fn == `CRS_FN_SBC)};
        o_res = sum[7:0];
        o_c   = sum[8];
        o_v   = (i_a[7] != i_b[7]) && (sum[7] != i_a[7]);
      end
      `CRS_FN_AND: o_res = i_a & i_b;
      `CRS_FN_ORA: o_res = i_a | i_b;
      `CRS_FN_EOR: o_res = i_a ^ i_b;
      `CRS_FN_LSL: begin
        o_res = {i_a[6:0], 1'b0};
        o_c   = i_a[7];
        o_v   = i_a[7] ^ i_a[6];
      end
      `CRS_FN_ROL: begin
        o_res = {i_a[6:0], i_c};
        o_c   = i_a[7];
        o_v   = i_a[7] ^ i_a[6];
      end
      `CRS_FN_LSR: begin
        o_res = {1'b0, i_a[7:1]};
        o_c   = i_a[0];
        o_v   = i_a[0];
      end
      `CRS_FN_ROR: begin
        o_res = {i_c, i_a[7:1]};
        o_c   = i_a[0];
        o_v   = i_c ^ i_a[0];
      end
      `CRS_FN_ASR: begin
        o_res = {i_a[7], i_a[7:1]};
        o_c   = i_a[0];
        o_v   = i_a[7] ^ i_a[0];
      end
      `CRS_FN_DEC_ADJ: begin
        // Decimal correction picks its factor from the nibble carry and carry
        corr[3:0] = (i_h || (i_a[3:0] > 4'h9)) ? 4'h6 : 4'h0;
        corr[7:4] = (i_c || (i_a > 8'h99)) ? 4'h6 : 4'h0;
        o_res     = i_a + corr;
        o_c       = i_c || (i_a > 8'h99);
        o_v       = 1'b0;
      end
      default: o_res = i_a;
    endcase
  end
endmodule // crs_flag_unit

// [hw/crs_core.v]
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ns
`include "crs_map.vh"
// How it works
// - An 8-bit work register holds operands and receives ALU results.
// - A 16-bit index pair, upper and lower byte, bases indexed addresses.
// - Reset presets the stack pointer to 00ff.
// - The stack low reload op sets the low byte to ff only.
// - Stack pointer names next free slot; push decrements, pull increments.
// - Stack-relative address is stack pointer plus an 8 or 16-bit offset.
// - Program counter steps on each fetch; jumps and interrupts load it.
// - Leaving reset, the program counter loads from fffe high, ffff low.
// - Flag register bits 6 and 5 always read one and never change.
// - Signed wrap flag marks two's complement overflow; signed branches use it.
// - Nibble carry marks carry from bit 3 to 4; decimal adjust uses it.
// - Maskable interrupts are ignored while the mask flag is one.
// - Interrupt entry sets the mask after saving registers, before the vector fetch.
// - Entry does not save the upper index byte; software pushes it itself.
// - With the mask clear, the highest-priority pending request goes first.
// - Interrupt return pulls saved registers, flag register included.
// - Reset sets the mask; the mask clear op or an interrupt return that pulls a clear mask clears it.
// - Result MSB flag follows bit 7 of the result.
// - Null result flag is set when the result is 00.
// - Carry flag marks carry out of bit 7, borrow, shifts and rotates.
// - Addresses are 16 bits wide, covering a unified 64 Kbyte space.
module crs_core #(
  parameter IRQ_N = 4
) (
  input  wire             i_ref_clk,    // Core clock
  input  wire             i_rst,        // Asynchronous reset, active high
  input  wire             i_wb_cyc,     // Wishbone cycle
  input  wire             i_wb_stb,     // Wishbone strobe
  input  wire             i_wb_we,      // Wishbone write enable
  input  wire [7:0]       i_wb_adr,     // Wishbone byte address
  input  wire [31:0]      i_wb_dat,     // Wishbone write data
  input  wire [3:0]       i_wb_sel,     // Wishbone byte lanes
  output reg  [31:0]      o_wb_dat,     // Wishbone read data
  output reg              o_wb_ack,     // Wishbone acknowledge
  input  wire             i_op_valid,   // Operation strobe
  input  wire [3:0]       i_op_code,    // Operation code
  input  wire [15:0]      i_op_data,    // Operation data
  input  wire [3:0]       i_alu_fn,     // ALU function
  input  wire             i_boundary,   // Instruction boundary
  input  wire [1:0]       i_ea_mode,    // Address mode
  input  wire [15:0]      i_ea_off,     // Address offset
  output reg  [15:0]      o_ea,         // Effective address
  input  wire [1:0]       i_br_cond,    // Signed branch kind
  output wire             o_br_taken,   // Signed branch decision
  input  wire [IRQ_N-1:0] i_irq_req,    // Maskable requests, bit 0 first
  output wire             o_mem_req,    // Memory request
  output wire             o_mem_we,     // Memory write
  output wire [15:0]      o_mem_addr,   // Memory address
  output wire [7:0]       o_mem_wdata,  // Memory write data
  input  wire [7:0]       i_mem_rdata,  // Memory read data
  input  wire             i_mem_ack,    // Memory acknowledge
  output wire             o_busy        // Stack or vector sequence running
);
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam ST_RUN   = 3'd0;
  localparam ST_VECH  = 3'd1;
  localparam ST_VECL  = 3'd2;
  localparam ST_IPUSH = 3'd3;
  localparam ST_RPULL = 3'd4;
  localparam ST_PUSH  = 3'd5;
  localparam ST_PULL  = 3'd6;
  localparam LAST_STEP = 3'd4;

  reg  [7:0]  work;
  reg  [7:0]  idx_hi;
  reg  [7:0]  idx_lo;
  reg  [15:0] sp;
  reg  [15:0] pc;
  reg  [7:0]  flags;
  reg  [2:0]  state;
  reg  [2:0]  step;
  reg  [15:0] vec_addr;
  reg         one_sel;
  reg  [7:0]  vec_hi;

  wire [7:0]  alu_res;
  wire        alu_v;
  wire        alu_h;
  wire        alu_c;
  wire        alu_n;
  wire        alu_z;
  wire        wb_hit;
  wire        op_go;
  wire        irq_go;
  wire        sgn_lt;
  wire [15:0] sp_inc;
  wire [15:0] sp_dec;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Lowest request index wins
  function [7:0] irq_pick;
    input [IRQ_N-1:0] req;
    integer k;
    begin
      irq_pick = 8'h00;
      for (k = IRQ_N - 1; k >= 0; k = k - 1) begin
        if (req[k]) begin
          irq_pick = k[7:0];
        end
      end
    end
  endfunction

  // Entry push order; the return pull walks it backwards
  function [7:0] push_byte;
    input [2:0]  s;
    input [15:0] p;
    input [7:0]  lo;
    input [7:0]  a;
    input [7:0]  f;
    begin
      case (s)
        3'd0:    push_byte = p[7:0];
        3'd1:    push_byte = p[15:8];
        3'd2:    push_byte = lo;
        3'd3:    push_byte = a;
        default: push_byte = f;
      endcase
    end
  endfunction

  function [15:0] lane_merge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  sel;
    begin
      lane_merge[7:0]  = sel[0] ? nw[7:0] : old[7:0];
      lane_merge[15:8] = sel[1] ? nw[15:8] : old[15:8];
    end
  endfunction

  // ----------------------------------------------------------------
  // Arithmetic and flags
  // ----------------------------------------------------------------
  crs_flag_unit u_flag (
    .i_fn  (i_alu_fn),
    .i_a   (work),
    .i_b   (i_op_data[7:0]),
    .i_c   (flags[`CRS_F_C]),
    .i_h   (flags[`CRS_F_H]),
    .o_res (alu_res),
    .o_v   (alu_v),
    .o_h   (alu_h),
    .o_c   (alu_c),
    .o_n   (alu_n),
    .o_z   (alu_z)
  );

  assign sgn_lt = flags[`CRS_F_N] ^ flags[`CRS_F_V];
  assign o_br_taken = (i_br_cond == 2'd0) ? ~(flags[`CRS_F_Z] | sgn_lt) :  // greater
                      (i_br_cond == 2'd1) ? ~sgn_lt :                      // greater or equal
                      (i_br_cond == 2'd2) ? (flags[`CRS_F_Z] | sgn_lt) :   // less or equal
                      sgn_lt;                                              // less

  // ----------------------------------------------------------------
  // Memory port
  // ----------------------------------------------------------------
  assign sp_inc = sp + 16'h0001;
  assign sp_dec = sp - 16'h0001;
  assign o_busy = (state != ST_RUN);
  assign o_mem_req = o_busy;
  assign o_mem_we = (state == ST_IPUSH) || (state == ST_PUSH);
  // Pushes write at the free slot, pulls read one above it
  assign o_mem_addr = (state == ST_VECH) ? vec_addr :
                      (state == ST_VECL) ? (vec_addr + 16'h0001) :
                      o_mem_we ? sp : sp_inc;
  assign o_mem_wdata = (state == ST_PUSH) ? (one_sel ? idx_hi : work) :
                       push_byte(step, pc, idx_lo, work, flags);

  assign op_go  = i_op_valid && (state == ST_RUN);
  // A request is only taken at a boundary, never mid instruction
  assign irq_go = (state == ST_RUN) && i_boundary && !op_go &&
                  !flags[`CRS_F_I] && (|i_irq_req);

  // ----------------------------------------------------------------
  // Effective address
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ea <= 16'h0000;
    end else begin
      case (i_ea_mode)
        `CRS_EA_INDEX: o_ea <= {idx_hi, idx_lo} + i_ea_off;
        `CRS_EA_STACK: o_ea <= sp + i_ea_off;
        default:       o_ea <= i_ea_off;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Answer comes one cycle after the strobe and drops the cycle after
  assign wb_hit = i_wb_cyc && i_wb_stb && !o_wb_ack;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= wb_hit;
      if (wb_hit && !i_wb_we) begin
        case (i_wb_adr)
          `CRS_ADR_WORK:   o_wb_dat <= {24'h000000, work};
          `CRS_ADR_PAIR:   o_wb_dat <= {16'h0000, idx_hi, idx_lo};
          `CRS_ADR_STACK:  o_wb_dat <= {16'h0000, sp};
          `CRS_ADR_PC:     o_wb_dat <= {16'h0000, pc};
          `CRS_ADR_FLAG:   o_wb_dat <= {24'h000000, flags};
          `CRS_ADR_STATUS: o_wb_dat <= {24'h000000, step, state, 1'b0, o_busy};
          default:         o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register set and sequencer
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      work     <= 8'h00;
      idx_hi   <= 8'h00;
      idx_lo   <= 8'h00;
      sp       <= `CRS_SP_RESET;
      pc       <= 16'h0000;
      flags    <= `CRS_FLAG_RESET;
      state    <= ST_VECH;
      step     <= 3'd0;
      vec_addr <= `CRS_RESET_VEC;
      one_sel  <= 1'b0;
      vec_hi   <= 8'h00;
    end else begin
      // Software writes land first so that a same-cycle operation wins
      if (wb_hit && i_wb_we) begin
        case (i_wb_adr)
          `CRS_ADR_WORK: begin
            if (i_wb_sel[0]) begin
              work <= i_wb_dat[7:0];
            end
          end
          `CRS_ADR_PAIR: begin
            {idx_hi, idx_lo} <= lane_merge({idx_hi, idx_lo}, i_wb_dat[15:0], i_wb_sel[1:0]);
          end
          `CRS_ADR_STACK: sp <= lane_merge(sp, i_wb_dat[15:0], i_wb_sel[1:0]);
          `CRS_ADR_PC:    pc <= lane_merge(pc, i_wb_dat[15:0], i_wb_sel[1:0]);
          `CRS_ADR_FLAG: begin
            // Software may set the mask but never clear it this way
            if (i_wb_sel[0]) begin
              flags <= (i_wb_dat[7:0] | `CRS_FLAG_FIXED |
                       (flags & (8'h01 << `CRS_F_I)));
            end
          end
          default: ;
        endcase
      end
      case (state)
        ST_RUN: begin
          if (irq_go) begin
            vec_addr <= `CRS_IRQ_VEC_TOP - {7'h00, irq_pick(i_irq_req), 1'b0};
            step     <= 3'd0;
            state    <= ST_IPUSH;
          end else if (op_go) begin
            case (i_op_code)
              `CRS_OP_LDA: begin
                work               <= i_op_data[7:0];
                flags[`CRS_F_V]    <= 1'b0;
                flags[`CRS_F_N]    <= i_op_data[7];
                flags[`CRS_F_Z]    <= (i_op_data[7:0] == 8'h00);
              end
              `CRS_OP_LDHX: {idx_hi, idx_lo} <= i_op_data;
              `CRS_OP_LDSP: sp <= i_op_data;
              `CRS_OP_JUMP: pc <= i_op_data;
              `CRS_OP_FETCH: pc <= pc + 16'h0001;
              `CRS_OP_ALU: begin
                work               <= alu_res;
                flags[`CRS_F_V]    <= alu_v;
                flags[`CRS_F_H]    <= alu_h;
                flags[`CRS_F_N]    <= alu_n;
                flags[`CRS_F_Z]    <= alu_z;
                flags[`CRS_F_C]    <= alu_c;
              end
              `CRS_OP_MASK: flags[`CRS_F_I] <= 1'b1;
              `CRS_OP_UNMASK: flags[`CRS_F_I] <= 1'b0;
              `CRS_OP_RELOAD: sp[7:0] <= `CRS_SP_LOW_LOAD;
              `CRS_OP_PUSH_WK, `CRS_OP_PUSH_HI: begin
                one_sel <= (i_op_code == `CRS_OP_PUSH_HI);
                state   <= ST_PUSH;
              end
              `CRS_OP_PULL_WK, `CRS_OP_PULL_HI: begin
                one_sel <= (i_op_code == `CRS_OP_PULL_HI);
                state   <= ST_PULL;
              end
              `CRS_OP_RETURN: begin
                step  <= 3'd0;
                state <= ST_RPULL;
              end
              default: ;
            endcase
          end
        end
        ST_IPUSH: begin
          if (i_mem_ack) begin
            sp <= sp_dec;
            if (step == LAST_STEP) begin
              // Mask goes up only once every byte is on the stack
              flags[`CRS_F_I] <= 1'b1;
              state           <= ST_VECH;
            end else begin
              step <= step + 3'd1;
            end
          end
        end
        ST_RPULL: begin
          if (i_mem_ack) begin
            sp <= sp_inc;
            case (step)
              3'd0: flags <= i_mem_rdata | `CRS_FLAG_FIXED;
              3'd1: work <= i_mem_rdata;
              3'd2: idx_lo <= i_mem_rdata;
              3'd3: pc[15:8] <= i_mem_rdata;
              default: pc[7:0] <= i_mem_rdata;
            endcase
            if (step == LAST_STEP) begin
              state <= ST_RUN;
            end else begin
              step <= step + 3'd1;
            end
          end
        end
        ST_PUSH: begin
          if (i_mem_ack) begin
            sp    <= sp_dec;
            state <= ST_RUN;
          end
        end
        ST_PULL: begin
          if (i_mem_ack) begin
            sp <= sp_inc;
            if (one_sel) begin
              idx_hi <= i_mem_rdata;
            end else begin
              work <= i_mem_rdata;
            end
            state <= ST_RUN;
          end
        end
        ST_VECH: begin
          if (i_mem_ack) begin
            vec_hi <= i_mem_rdata;
            state  <= ST_VECL;
          end
        end
        ST_VECL: begin
          if (i_mem_ack) begin
            pc    <= {vec_hi, i_mem_rdata};
            state <= ST_RUN;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end
endmodule // crs_core

// [dv/crs_core_asserts.sv]
`timescale 1ns/1ns
module crs_core_chk (
  input wire        i_ref_clk,   // Clock
  input wire        i_rst,       // Reset
  input wire        i_wb_cyc,    // Cycle
  input wire        i_wb_stb,    // Strobe
  input wire        i_wb_we,     // Write
  input wire [7:0]  i_wb_adr,    // Address
  input wire [31:0] o_wb_dat,    // Read data
  input wire        o_wb_ack,    // Ack
  input wire        o_mem_req,   // Memory request
  input wire        o_mem_we,    // Memory write
  input wire [15:0] o_mem_addr,  // Memory address
  input wire        i_mem_ack    // Memory ack
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  chk_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus access not acknowledged");
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  chk_mem_hold: assert property (o_mem_req && !i_mem_ack |=> $stable(o_mem_addr) && $stable(o_mem_we))
    else $error("memory request moved before ack");
  chk_boot_addr: assert property ($fell(i_rst) |-> o_mem_addr == 16'hfffe && !o_mem_we)
    else $error("first fetch not at fffe");
  chk_vec_pair: assert property (o_mem_req && i_mem_ack && !o_mem_we && o_mem_addr == 16'hfffe
    |=> o_mem_req && o_mem_addr == 16'hffff)
    else $error("vector low byte not fetched from ffff");
  chk_push_step: assert property (o_mem_req && o_mem_we && i_mem_ack ##1 o_mem_req && o_mem_we
    |-> o_mem_addr == $past(o_mem_addr) - 16'h1)
    else $error("push address did not step down");
  chk_pull_step: assert property (o_mem_req && !o_mem_we && i_mem_ack ##1 o_mem_req && !o_mem_we
    |-> o_mem_addr == $past(o_mem_addr) + 16'h1)
    else $error("read address did not step up");
  chk_flag_fixed: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 8'h10
    |-> o_wb_dat[6:5] == 2'b11)
    else $error("flag bits 6 and 5 not one");
  chk_unmapped: assert property (o_wb_ack && !i_wb_we && i_wb_adr > 8'h14 |-> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
endmodule // crs_core_chk
bind crs_core crs_core_chk chk (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
  .o_wb_dat, .o_wb_ack, .o_mem_req, .o_mem_we, .o_mem_addr, .i_mem_ack);

// [dv/crs_mem_model.sv]
`timescale 1ns/1ns
module crs_mem_model (
  input  wire        i_clk,    // Core clock
  input  wire        i_req,    // Byte request
  input  wire        i_we,     // Write
  input  wire [15:0] i_addr,   // Address
  input  wire [7:0]  i_wdata,  // Write data
  input  wire [1:0]  i_wait,   // Wait states
  output reg  [7:0]  o_rdata,  // Read data
  output reg         o_ack     // Answer
);
  reg [7:0] ram [0:65535];
  reg [1:0] cnt = 2'h0;
  initial o_ack = 1'b0;
  initial o_rdata = 8'h00;
  // Read data toggles outside the answer so a late sample cannot pass by luck
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack && cnt < i_wait)
      cnt <= cnt + 2'h1;
    else if (i_req && !o_ack) begin
      cnt <= 2'h0;
      o_ack <= 1'b1;
      if (i_we)
        ram[i_addr] <= i_wdata;
      else
        o_rdata <= ram[i_addr];
    end
  end
endmodule // crs_mem_model

// [dv/tb_top.sv]
`timescale 1ns/1ns
`include "crs_map.vh"
module tb_top;
  logic        i_ref_clk = 1'b0, i_rst = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0;
  logic        i_wb_we = 1'b0, i_op_valid = 1'b0, i_boundary = 1'b0;
  logic [7:0]  i_wb_adr = 8'h00;
  logic [31:0] i_wb_dat = '0, q;
  logic [3:0]  i_wb_sel = 4'hf, i_op_code = 4'h0, i_alu_fn = 4'h0, i_irq_req = 4'h0;
  logic [15:0] i_op_data = '0, i_ea_off = '0;
  logic [1:0]  i_ea_mode = 2'h0, i_br_cond = 2'h0, mwait = 2'h0;
  wire  [31:0] o_wb_dat;
  wire  [15:0] o_ea, o_mem_addr;
  wire  [7:0]  o_mem_wdata, i_mem_rdata;
  wire         o_wb_ack, o_br_taken, o_mem_req, o_mem_we, i_mem_ack, o_busy;
  int          fails = 0, comparisons = 0;
  // Op, function, operand, then expected work register and flags
  logic [31:0] alu [9] = '{32'h100f0f68, 32'h60011078, 32'h60f0006b, 32'h107f7f69,
    32'h600180fc, 32'h62017ff8, 32'h6c00857c, 32'h680042f9, 32'h1080807d};
  always #10 i_ref_clk = ~i_ref_clk;
  crs_core #(.IRQ_N(4)) uut (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack, .i_op_valid, .i_op_code, .i_op_data, .i_alu_fn,
    .i_boundary, .i_ea_mode, .i_ea_off, .o_ea, .i_br_cond, .o_br_taken, .i_irq_req, .o_mem_req,
    .o_mem_we, .o_mem_addr, .o_mem_wdata, .i_mem_rdata, .i_mem_ack, .o_busy);
  crs_mem_model mem_i (.i_clk(i_ref_clk), .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_wait(mwait), .o_rdata(i_mem_rdata),
    .o_ack(i_mem_ack));
  task automatic check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, w, a, d};
    do @(posedge i_ref_clk); while (o_wb_ack !== 1'b1);
    q = o_wb_dat;
    {i_wb_cyc, i_wb_stb} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, '0);
    check(nm, q, e);
  endtask
  task automatic idle;
    do @(posedge i_ref_clk); while (o_busy !== 1'b0);
  endtask
  task automatic op(input logic [3:0] c, input logic [15:0] d, input logic [3:0] f);
    @(posedge i_ref_clk);
    {i_op_valid, i_op_code, i_op_data, i_alu_fn} <= {1'b1, c, d, f};
    @(posedge i_ref_clk);
    i_op_valid <= 1'b0;
    idle();
  endtask
  task automatic ea(input logic [1:0] m, input logic [15:0] o, e, input string nm);
    @(posedge i_ref_clk);
    {i_ea_mode, i_ea_off} <= {m, o};
    repeat (2) @(posedge i_ref_clk);
    check(nm, o_ea, e);
  endtask
  task automatic wrap_up;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
  initial begin
    mem_i.ram[16'hfffe] = 8'h12;
    mem_i.ram[16'hffff] = 8'h34;
    mem_i.ram[16'hfffa] = 8'h20;
    mem_i.ram[16'hfffb] = 8'h00;
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    idle();
    rd(8'h0c, 32'h1234, "pc");
    rd(8'h08, 32'h00ff, "sp");
    rd(8'h10, 32'h68, "flags");
    wb(1'b1, 8'h10, 32'h0);
    rd(8'h10, 32'h68, "flags_w");
    rd(8'h20, 32'h0, "unmapped");
    wb(1'b1, 8'h04, 32'habcd);
    rd(8'h04, 32'habcd, "pair");
    wb(1'b1, 8'h08, 32'h1234);
    op(`CRS_OP_RELOAD, 16'h0, 4'h0);
    rd(8'h08, 32'h12ff, "sp_low");
    ea(`CRS_EA_INDEX, 16'h0010, 16'habdd, "ea_idx");
    ea(`CRS_EA_STACK, 16'h0005, 16'h1304, "ea_sp");
    foreach (alu[k]) begin
      op(alu[k][31:28], {8'h00, alu[k][23:16]}, alu[k][27:24]);
      rd(8'h00, alu[k][15:8], "work");
      rd(8'h10, alu[k][7:0], "alu_flags");
    end
    i_br_cond <= 2'h1;
    @(posedge i_ref_clk);
    check("br_ge", o_br_taken, 1'b0);
    i_br_cond <= 2'h3;
    @(posedge i_ref_clk);
    check("br_lt", o_br_taken, 1'b1);
    mwait <= 2'h2;
    op(`CRS_OP_PUSH_WK, 16'h0, 4'h0);
    check("push_mem", mem_i.ram[16'h12ff], 8'h80);
    rd(8'h08, 32'h12fe, "sp_push");
    op(`CRS_OP_LDA, 16'h0, 4'h0);
    op(`CRS_OP_PULL_WK, 16'h0, 4'h0);
    rd(8'h00, 32'h80, "pull_a");
    rd(8'h08, 32'h12ff, "sp_pull");
    wb(1'b1, 8'h0c, 32'h4000);
    {i_boundary, i_irq_req} <= {1'b1, 4'h6};
    repeat (4) @(posedge i_ref_clk);
    check("masked", o_busy, 1'b0);
    op(`CRS_OP_UNMASK, 16'h0, 4'h0);
    repeat (2) @(posedge i_ref_clk);
    idle();
    i_irq_req <= 4'h0;
    rd(8'h0c, 32'h2000, "vector");
    rd(8'h08, 32'h12fa, "sp_entry");
    check("idx_lo", mem_i.ram[16'h12fd], 8'hcd);
    check("saved_mask", mem_i.ram[16'h12fb][3], 1'b0);
    wb(1'b0, 8'h10, '0);
    check("mask_set", q[3], 1'b1);
    op(`CRS_OP_RETURN, 16'h0, 4'h0);
    rd(8'h0c, 32'h4000, "pc_ret");
    rd(8'h08, 32'h12ff, "sp_ret");
    wb(1'b0, 8'h10, '0);
    check("mask_ret", q[3], 1'b0);
    op(`CRS_OP_FETCH, 16'h0, 4'h0);
    rd(8'h0c, 32'h4001, "pc_step");
    op(`CRS_OP_PUSH_HI, 16'h0, 4'h0);
    check("push_hi", mem_i.ram[16'h12ff], 8'hab);
    wb(1'b1, 8'h04, 32'h0);
    op(`CRS_OP_PULL_HI, 16'h0, 4'h0);
    rd(8'h04, 32'hab00, "pull_hi");
    wrap_up();
  end
endmodule // tb_top
